/* pkg/ebr_pkg.sv */
// ebr_pkg: constants and types for the external bus ready/wait control
// assumes one system clock; bus phases advance on a divider enable
// Functional notes
// R01: external ready lengthens or ends bus cycles
// R02: ready polarity selectable
// R03: sync mode samples ready directly, shortest cycle
// R04: async mode adds sync stage, one waitstate
// R05: async ready held one period plus setup
// R06: ready may drop after strobe rising edge
// R07: ready removed before next cycle's sample
// R08: inactive ready inserts another waitstate, resample
// R09: active ready terminates current cycle
// R10: async sampling point later than sync
// R11: ready ignored during programmed access waitstates
// R12: strobe held through waitstates, released on ready
package ebr_pkg;
   localparam int unsigned EBR_CLK_DIV = 2;
   localparam int unsigned EBR_DIV_W = 4;
   localparam int unsigned EBR_ACC_W = 6;
   localparam int unsigned EBR_WAIT_W = 8;
   localparam logic [EBR_ACC_W-1:0] EBR_ACC_MIN = 6'h01;
   localparam logic [EBR_ACC_W-1:0] EBR_ACC_MAX = 6'h20;
   localparam logic [EBR_DIV_W-1:0] EBR_DIV_ZERO = 4'h0;
   localparam logic [EBR_ACC_W-1:0] EBR_ACC_ZERO = 6'h00;
   localparam logic [EBR_WAIT_W-1:0] EBR_WAIT_ZERO = 8'h00;
   localparam logic [EBR_WAIT_W-1:0] EBR_WAIT_ONE = 8'h01;
   localparam logic [EBR_ACC_W-1:0] EBR_ACC_ONE = 6'h01;
   localparam logic [EBR_DIV_W-1:0] EBR_DIV_ONE = 4'h1;

   typedef enum logic [2:0] {
      EBR_IDLE,
      EBR_ADDR,
      EBR_ACCESS,
      EBR_READY_WAIT,
      EBR_HOLD
   } ebr_state_t;
endpackage : ebr_pkg

/* hdl/ebr_sync2.sv */
// ebr_sync2: two-stage level synchroniser
// assumes the input may change at any time relative to clock
`timescale 1ns/100ps
`default_nettype none
module ebr_sync2 (
   // clock and reset
   input wire logic clock,
   input wire logic srst,
   // level in and out
   input wire logic d_in,
   output logic q_out
);
   logic meta_r;

   // first stage feeds only the second one
   always_ff @(posedge clock) begin
      if (srst) begin
         meta_r <= 1'b0;
         q_out <= 1'b0;
      end else begin
         meta_r <= d_in;
         q_out <= meta_r;
      end
   end
endmodule : ebr_sync2
`default_nettype wire

/* hdl/ebr_ready_ctrl.sv */
// ebr_ready_ctrl: bus cycle sequencer with ready-controlled waitstates
// assumes a core issues one cycle at a time and the ready pin comes from outside
`timescale 1ns/100ps
`default_nettype none
module ebr_ready_ctrl #(
   parameter int unsigned CLK_DIV = ebr_pkg::EBR_CLK_DIV
) (
   // clock and reset
   input wire logic clock,
   input wire logic srst,
   // core request side
   input wire logic cyc_start,
   input wire logic cyc_write,
   output logic cyc_busy,
   output logic cyc_done,
   // configuration levels
   input wire logic ready_enable,
   input wire logic ready_async,
   input wire logic ready_active_high,
   input wire logic [ebr_pkg::EBR_ACC_W-1:0] access_phase_length,
   // bus pins
   input wire logic ready_pin,
   output logic bus_reference_clock_out,
   output logic ale_out,
   output logic rd_n_out,
   output logic wr_n_out,
   // status
   output logic [ebr_pkg::EBR_WAIT_W-1:0] wait_count
);
   localparam logic [ebr_pkg::EBR_DIV_W-1:0] DIV_LAST = ebr_pkg::EBR_DIV_W'(CLK_DIV - 1);
   localparam logic [ebr_pkg::EBR_DIV_W-1:0] DIV_HALF = ebr_pkg::EBR_DIV_W'(CLK_DIV / 2);

   ebr_pkg::ebr_state_t state_r;
   ebr_pkg::ebr_state_t state_nxt;
   logic [ebr_pkg::EBR_DIV_W-1:0] div_r;
   logic bus_tick;
   logic [ebr_pkg::EBR_ACC_W-1:0] acc_len_r;
   logic [ebr_pkg::EBR_ACC_W-1:0] acc_cnt_r;
   logic write_r;
   logic async_r;
   logic use_ready_r;
   logic start_pend_r;
   logic ready_sync;
   logic ready_raw_act;
   logic ready_sync_act;
   logic ready_seen;
   logic acc_last;

   // bus clock divider; phases change only on the tick at the end of a bus period
   always_ff @(posedge clock) begin
      if (srst) begin
         div_r <= ebr_pkg::EBR_DIV_ZERO;
      end else if (div_r == DIV_LAST) begin
         div_r <= ebr_pkg::EBR_DIV_ZERO;
      end else begin
         div_r <= div_r + ebr_pkg::EBR_DIV_ONE;
      end
   end

   assign bus_tick = (div_r == DIV_LAST);

   always_ff @(posedge clock) begin
      if (srst) begin
         bus_reference_clock_out <= 1'b0;
      end else begin
         bus_reference_clock_out <= (div_r == DIV_LAST) || (div_r < DIV_HALF - ebr_pkg::EBR_DIV_ONE);
      end
   end

   // extra stage for the asynchronous mode; costs latency, buys metastability margin
   ebr_sync2 u_ready_sync (
      .clock(clock),
      .srst(srst),
      .d_in(ready_pin),
      .q_out(ready_sync)
   );

   // polarity select applied to both paths
   assign ready_raw_act = ready_active_high ? ready_pin : ~ready_pin; // see R02
   assign ready_sync_act = ready_active_high ? ready_sync : ~ready_sync; // see R02

   // sync path reads the pin directly; async path reads the synchronised copy
   assign ready_seen = async_r ? ready_sync_act : ready_raw_act; // see R03 see R04

   assign acc_last = (acc_cnt_r == acc_len_r);

   // a start that arrives between ticks waits for the next bus period
   always_ff @(posedge clock) begin
      if (srst) begin
         start_pend_r <= 1'b0;
      end else if (bus_tick && state_r == ebr_pkg::EBR_IDLE) begin
         start_pend_r <= 1'b0;
      end else if (cyc_start && state_r == ebr_pkg::EBR_IDLE) begin
         start_pend_r <= 1'b1;
      end
   end

   // cycle attributes except ready polarity are frozen at start, so mid-cycle changes to them do no harm
   always_ff @(posedge clock) begin
      if (srst) begin
         write_r <= 1'b0;
         async_r <= 1'b0;
         use_ready_r <= 1'b0;
         acc_len_r <= ebr_pkg::EBR_ACC_MIN;
      end else if (bus_tick && state_r == ebr_pkg::EBR_IDLE && (start_pend_r || cyc_start)) begin
         write_r <= cyc_write;
         async_r <= ready_async;
         use_ready_r <= ready_enable; // see R01
         if (access_phase_length < ebr_pkg::EBR_ACC_MIN) begin
            acc_len_r <= ebr_pkg::EBR_ACC_MIN;
         end else if (access_phase_length > ebr_pkg::EBR_ACC_MAX) begin
            acc_len_r <= ebr_pkg::EBR_ACC_MAX;
         end else begin
            acc_len_r <= access_phase_length;
         end
      end
   end

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ebr_pkg::EBR_IDLE: begin
            if (start_pend_r || cyc_start) begin
               state_nxt = ebr_pkg::EBR_ADDR;
            end
         end
         ebr_pkg::EBR_ADDR: begin
            state_nxt = ebr_pkg::EBR_ACCESS;
         end
         ebr_pkg::EBR_ACCESS: begin
            // ready is not looked at until the programmed waitstates are done
            if (acc_last) begin // see R11
               if (!use_ready_r) begin
                  state_nxt = ebr_pkg::EBR_HOLD;
               end else if (async_r) begin
                  state_nxt = ebr_pkg::EBR_READY_WAIT; // see R04 see R10
               end else if (ready_seen) begin
                  state_nxt = ebr_pkg::EBR_HOLD; // see R09
               end else begin
                  state_nxt = ebr_pkg::EBR_READY_WAIT; // see R08
               end
            end
         end
         ebr_pkg::EBR_READY_WAIT: begin
            if (ready_seen) begin
               state_nxt = ebr_pkg::EBR_HOLD; // see R09
            end else begin
               state_nxt = ebr_pkg::EBR_READY_WAIT; // see R08
            end
         end
         ebr_pkg::EBR_HOLD: begin
            state_nxt = ebr_pkg::EBR_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         state_r <= ebr_pkg::EBR_IDLE;
      end else if (bus_tick) begin
         state_r <= state_nxt;
      end
   end

   // access phase counter
   always_ff @(posedge clock) begin
      if (srst) begin
         acc_cnt_r <= ebr_pkg::EBR_ACC_ONE;
      end else if (bus_tick) begin
         if (state_r == ebr_pkg::EBR_ACCESS && !acc_last) begin
            acc_cnt_r <= acc_cnt_r + ebr_pkg::EBR_ACC_ONE;
         end else if (state_r != ebr_pkg::EBR_ACCESS) begin
            acc_cnt_r <= ebr_pkg::EBR_ACC_ONE;
         end
      end
   end

   // waitstates inserted by ready in the current or last cycle; saturates
   always_ff @(posedge clock) begin
      if (srst) begin
         wait_count <= ebr_pkg::EBR_WAIT_ZERO;
      end else if (bus_tick) begin
         if (state_r == ebr_pkg::EBR_ADDR) begin
            wait_count <= ebr_pkg::EBR_WAIT_ZERO;
         end else if (state_nxt == ebr_pkg::EBR_READY_WAIT && wait_count != '1) begin
            wait_count <= wait_count + ebr_pkg::EBR_WAIT_ONE; // see R08
         end
      end
   end

   // address latch enable during the address phase
   always_ff @(posedge clock) begin
      if (srst) begin
         ale_out <= 1'b0;
      end else if (bus_tick) begin
         ale_out <= (state_nxt == ebr_pkg::EBR_ADDR);
      end
   end

   // strobe active through access and all ready waitstates, dropped when ready ends the cycle
   always_ff @(posedge clock) begin
      if (srst) begin
         rd_n_out <= 1'b1;
         wr_n_out <= 1'b1;
      end else if (bus_tick) begin
         rd_n_out <= !(!write_r && (state_nxt == ebr_pkg::EBR_ACCESS || state_nxt == ebr_pkg::EBR_READY_WAIT)); // see R12
         wr_n_out <= !(write_r && (state_nxt == ebr_pkg::EBR_ACCESS || state_nxt == ebr_pkg::EBR_READY_WAIT)); // see R12
      end
   end

   // done pulses once as the hold phase ends
   always_ff @(posedge clock) begin
      if (srst) begin
         cyc_done <= 1'b0;
      end else begin
         cyc_done <= bus_tick && (state_r == ebr_pkg::EBR_HOLD);
      end
   end

   assign cyc_busy = (state_r != ebr_pkg::EBR_IDLE) || start_pend_r;
endmodule : ebr_ready_ctrl
`default_nettype wire

/* sim/ebr_ready_monitor.sv */
// ebr_ready_monitor: port checks for ebr_ready_ctrl
// assumes access lengths 1..32 held steady during a cycle
`timescale 1ns/100ps
`default_nettype none
module ebr_ready_monitor #(
   parameter int unsigned CLK_DIV = 2
) (
   // clock and reset
   input wire logic clock,
   input wire logic srst,
   // watched ports
   input wire logic cyc_done,
   input wire logic ready_enable,
   input wire logic ready_async,
   input wire logic ready_active_high,
   input wire logic [5:0] access_phase_length,
   input wire logic ready_pin,
   input wire logic ale_out,
   input wire logic rd_n_out,
   input wire logic wr_n_out,
   input wire logic [7:0] wait_count
);
   wire logic sn = rd_n_out & wr_n_out;
   wire logic rdy = ready_pin == ready_active_high;
   logic [15:0] low_r;
   // counts strobe-low clocks so the length check spans the whole strobe pulse
   always_ff @(posedge clock) begin
      if (srst || sn) begin
         low_r <= 16'h0000;
      end else begin
         low_r <= low_r + 16'h0001;
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   sequence s_rel; $rose(sn); endsequence
   sequence s_sync; s_rel ##0 (ready_enable && !ready_async); endsequence
   sequence s_async; s_rel ##0 (ready_enable && ready_async); endsequence
   AST_ONE_STROBE: assert property (rd_n_out || wr_n_out)
      else $error("both strobes low");
   AST_ALE_IDLE: assert property (ale_out |-> sn)
      else $error("ale during strobe");
   AST_DONE_PULSE: assert property (cyc_done |=> !cyc_done)
      else $error("done too long");
   AST_DONE_AFTER: assert property (s_rel |-> ##[1:8] cyc_done)
      else $error("no done after strobe");
   AST_SYNC_END: assert property (s_sync |-> $past(rdy))
      else $error("ended without ready");
   AST_SYNC_HOLD: assert property (ready_enable && !ready_async && !sn && !rdy |=> !sn)
      else $error("strobe dropped while not ready");
   AST_ASYNC_WAIT: assert property (s_async |-> wait_count != 8'h00)
      else $error("async cycle without waitstate");
   AST_ASYNC_LATE: assert property (s_async |-> $past(rdy, 3))
      else $error("async ended before synchronised ready");
   AST_LEN: assert property (s_rel |-> low_r == 16'((access_phase_length + (ready_enable ? wait_count : 8'h00)) * CLK_DIV))
      else $error("strobe length wrong");
endmodule : ebr_ready_monitor
bind ebr_ready_ctrl ebr_ready_monitor #(.CLK_DIV(CLK_DIV)) mon (.*);
`default_nettype wire

/* sim/ebr_ready_model.sv */
// ebr_ready_model: external circuit answering with ready
// assumes one strobe at a time; delay counts strobe-low clocks
`timescale 1ns/100ps
`default_nettype none
module ebr_ready_model (
   // clock and reset
   input wire logic clock,
   input wire logic srst,
   // strobes and settings
   input wire logic rd_n_out,
   input wire logic wr_n_out,
   input wire logic active_high,
   input wire logic [7:0] delay,
   // ready pin
   output logic ready_pin
);
   logic [7:0] cnt_r;
   wire logic sl = !(rd_n_out && wr_n_out);
   always_ff @(posedge clock) begin
      if (srst || !sl) begin
         cnt_r <= 8'h00;
      end else if (cnt_r != 8'hff) begin
         cnt_r <= cnt_r + 8'h01;
      end
   end
   // built from edge state, so synchronous to the bus clock
   // held until the strobe rises, over a bus period
   // dropped with the strobe, before the next sample
   assign ready_pin = (sl && cnt_r >= delay) ^ !active_high;
endmodule : ebr_ready_model
`default_nettype wire

/* sim/test_ext_bus_ready_wait_control.sv */
// test_ext_bus_ready_wait_control: directed bench
// assumes CLK_DIV of 2 and the ready model as partner
`timescale 1ns/100ps
`default_nettype none
module test_ext_bus_ready_wait_control;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic cyc_start = 1'b0;
   logic cyc_write = 1'b0;
   logic ready_enable = 1'b1;
   logic ready_async = 1'b0;
   logic ready_active_high = 1'b1;
   logic [5:0] access_phase_length = 6'h01;
   logic [7:0] dly = 8'h00;
   wire logic ready_pin, cyc_busy, cyc_done, ale_out, rd_n_out, wr_n_out, bus_reference_clock_out;
   wire logic [7:0] wait_count;
   int mismatches = 0;
   int total_checks = 0;
   int ticks = 0;
   int low;
   ebr_ready_ctrl #(.CLK_DIV(2)) uut (.clock, .srst, .cyc_start, .cyc_write, .cyc_busy, .cyc_done,
      .ready_enable, .ready_async, .ready_active_high, .access_phase_length, .ready_pin,
      .bus_reference_clock_out, .ale_out, .rd_n_out, .wr_n_out, .wait_count);
   ebr_ready_model far (.clock, .srst, .rd_n_out, .wr_n_out, .active_high(ready_active_high),
      .delay(dly), .ready_pin);
   initial begin
      forever #2.5 clock = ~clock;
   end
   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : final_report
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // w of ff skips the exact waitstate checks
   task automatic run(input logic wr, input logic [5:0] len, input logic [7:0] d, input logic [7:0] w);
      int n;
      low = 0;
      cyc_write = wr;
      access_phase_length = len;
      dly = d;
      cyc_start = 1'b1;
      @(negedge clock);
      cyc_start = 1'b0;
      check("busy after start", cyc_busy, 1'b1);
      for (n = 0; n < 300 && cyc_done !== 1'b1; n++) begin
         if ((wr ? wr_n_out : rd_n_out) === 1'b0) begin
            // phases move on the bus clock's rising edge, so it is high as the strobe falls
            if (low == 0) check("bus clock at strobe", bus_reference_clock_out, 1'b1);
            low++;
         end
         @(negedge clock);
      end
      check("done", cyc_done, 1'b1);
      check("busy after done", cyc_busy, 1'b0);
      if (w != 8'hff) begin
         check("strobe clocks", 16'(low), 16'((len + w) * 2));
         check("waits", wait_count, w);
      end
   endtask : run
   task automatic t_sync;
      run(1'b0, 6'h01, 8'h00, 8'h00);
      run(1'b1, 6'h01, 8'h00, 8'h00);
      $display("test sync done");
   endtask : t_sync
   task automatic t_access;
      run(1'b0, 6'h03, 8'h00, 8'h00);
      $display("test access done");
   endtask : t_access
   task automatic t_waits;
      run(1'b1, 6'h02, 8'h08, 8'h03);
      $display("test waits done");
   endtask : t_waits
   task automatic t_pol;
      ready_active_high = 1'b0;
      run(1'b0, 6'h01, 8'h04, 8'h02);
      ready_active_high = 1'b1;
      $display("test polarity done");
   endtask : t_pol
   task automatic t_async;
      ready_async = 1'b1;
      run(1'b0, 6'h01, 8'h00, 8'h01);
      run(1'b0, 6'h01, 8'h06, 8'hff);
      check("late waits", wait_count >= 8'h02, 1'b1);
      ready_async = 1'b0;
      $display("test async done");
   endtask : t_async
   task automatic t_fixed;
      ready_enable = 1'b0;
      run(1'b0, 6'h04, 8'hff, 8'h00);
      ready_enable = 1'b1;
      $display("test fixed done");
   endtask : t_fixed
   // a cycle that never sees ready is cut by reset; the block must come back clean
   task automatic t_reset;
      dly = 8'hff;
      cyc_start = 1'b1;
      @(negedge clock);
      cyc_start = 1'b0;
      repeat (5) @(negedge clock);
      srst = 1'b1;
      repeat (2) @(negedge clock);
      srst = 1'b0;
      check("reset strobes", {14'h0, rd_n_out, wr_n_out}, 16'h0003);
      check("reset busy ale", {14'h0, cyc_busy, ale_out}, 16'h0000);
      check("reset waits", {8'h0, wait_count}, 16'h0000);
      run(1'b0, 6'h01, 8'h00, 8'h00);
      $display("test reset done");
   endtask : t_reset
   always @(posedge clock) begin
      ticks++;
      if (ticks == 5000) begin
         mismatches++;
         final_report();
      end
   end
   initial begin
      repeat (16) @(negedge clock);
      srst = 1'b0;
      @(negedge clock);
      t_sync();
      t_access();
      t_waits();
      t_pol();
      t_async();
      t_fixed();
      t_reset();
      final_report();
   end
endmodule : test_ext_bus_ready_wait_control
`default_nettype wire
